// File: common/dba_pkg.sv
// Shared constants, types and helpers for the DDR2 burst access block.
package dba_pkg;

  // ==========================================================================
  // Widths
  localparam int DQ_W = 16;
  localparam int DM_W = 2;
  localparam int BA_W = 2;
  localparam int A_W = 13;
  localparam int COL_W = 10;
  localparam int MEM_AW = 12;
  localparam int LAT_DEPTH = 16;
  localparam int SYNC_W = 39;

  // ==========================================================================
  // Register port map and reset values
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_MODE = 4'h8;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;

  // ==========================================================================
  // Mode register fields and reset values
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_WR_LSB = 9;
  localparam int EMR_AL_LSB = 3;
  localparam int AP_BIT = 10;
  localparam logic [2:0] BL_CODE4 = 3'h2;
  localparam logic [2:0] BL_CODE8 = 3'h3;
  localparam logic [1:0] BA_MR = 2'h0;
  localparam logic [1:0] BA_EMR1 = 2'h1;
  localparam logic BL8_RST = 1'b0;
  localparam logic BT_RST = 1'b0;
  localparam logic [2:0] CL_RST = 3'h3;
  localparam logic [2:0] AL_RST = 3'h0;
  localparam logic [2:0] WR_RST = 3'h2;
  localparam logic [4:0] HALF_BL4 = 5'h02;
  localparam logic [4:0] HALF_BL8 = 5'h04;

  // ==========================================================================
  // Command codes as {ras_b, cas_b, we_b}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic valid;
    logic wr;
    logic ap;
    logic [BA_W-1:0] bank;
    logic [COL_W-1:0] col;
  } dba_cmd_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD = 3'b010,
    ST_WR = 3'b100
  } dba_state_e;

  // ==========================================================================
  // Column of a given beat inside its aligned group.
  function automatic logic [COL_W-1:0] dba_beat_col(
    input logic [COL_W-1:0] start,
    input logic [2:0] idx,
    input logic bl8,
    input logic il
  );
    logic [1:0] low;
    logic hi;
    low = il ? (start[1:0] ^ idx[1:0]) : 2'(start[1:0] + idx[1:0]);
    hi = bl8 ? (start[2] ^ idx[2]) : start[2];
    return {start[COL_W-1:3], hi, low};
  endfunction : dba_beat_col

endpackage : dba_pkg

// File: logic/dba_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module dba_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  // ==========================================================================
  // Synchroniser
  // The first stage feeds only the second; nothing else may look at it.
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule : dba_sync

// File: logic/dba_burst_access.sv
// Burst read and write engine of a four-bank x16 DDR2 memory device.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dba_burst_access (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_ck,
  input wire logic i_cs_b,
  input wire logic i_ras_b,
  input wire logic i_cas_b,
  input wire logic i_we_b,
  input wire logic [dba_pkg::BA_W-1:0] i_ba,
  input wire logic [dba_pkg::A_W-1:0] i_addr,
  input wire logic [dba_pkg::DQ_W-1:0] i_dq,
  input wire logic [dba_pkg::DM_W-1:0] i_dm,
  input wire logic i_dqs,
  output logic [dba_pkg::DQ_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_dqs,
  output logic o_dqs_oe,
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);

  // ==========================================================================
  // Pin synchronisation and edge detection
  logic [dba_pkg::SYNC_W-1:0] pins_raw;
  logic [dba_pkg::SYNC_W-1:0] pins_s;
  logic ck_s, cs_b_s, dqs_s;
  logic [2:0] cmd_code;
  logic [dba_pkg::BA_W-1:0] ba_s;
  logic [dba_pkg::A_W-1:0] addr_s;
  logic [dba_pkg::DQ_W-1:0] dq_s;
  logic [dba_pkg::DM_W-1:0] dm_s;
  logic ck_prev_q, dqs_prev_q;
  logic ck_rise, ck_fall, dqs_rise, dqs_fall;

  assign pins_raw = {i_ck, i_cs_b, i_ras_b, i_cas_b, i_we_b, i_ba, i_addr,
                     i_dq, i_dm, i_dqs};

  dba_sync #(.W(dba_pkg::SYNC_W)) u_sync (
    .i_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_d(pins_raw),
    .o_q(pins_s)
  );

  assign {ck_s, cs_b_s, cmd_code, ba_s, addr_s, dq_s, dm_s, dqs_s} = pins_s;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ck_prev_q <= 1'b0;
      dqs_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_s;
      dqs_prev_q <= dqs_s;
    end
  end

  assign ck_rise = ck_s & ~ck_prev_q;
  assign ck_fall = ~ck_s & ck_prev_q;
  assign dqs_rise = dqs_s & ~dqs_prev_q;
  assign dqs_fall = ~dqs_s & dqs_prev_q;

  // ==========================================================================
  // Command decode
  // The burst stop code falls through every decode below and acts as a no-op.
  logic en_q;
  logic cmd_go, cmd_rd, cmd_wr, cmd_mrs, cmd_pre, cmd_act;

  assign cmd_go = ck_rise & ~cs_b_s & en_q;
  assign cmd_rd = cmd_go & (cmd_code == dba_pkg::CMD_RD);
  assign cmd_wr = cmd_go & (cmd_code == dba_pkg::CMD_WR);
  assign cmd_mrs = cmd_go & (cmd_code == dba_pkg::CMD_MRS);
  assign cmd_pre = cmd_go & (cmd_code == dba_pkg::CMD_PRE);
  assign cmd_act = cmd_go & (cmd_code == dba_pkg::CMD_ACT);

  // ==========================================================================
  // Mode registers
  logic bl8_q, bt_q;
  logic [2:0] cl_q, al_q, wr_q;
  logic [3:0] rl, wl;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bl8_q <= dba_pkg::BL8_RST;
      bt_q <= dba_pkg::BT_RST;
      cl_q <= dba_pkg::CL_RST;
      al_q <= dba_pkg::AL_RST;
      wr_q <= dba_pkg::WR_RST;
    end else if (cmd_mrs && ba_s == dba_pkg::BA_MR) begin
      if (addr_s[dba_pkg::MR_BL_LSB +: 3] == dba_pkg::BL_CODE4) begin
        bl8_q <= 1'b0;
      end else if (addr_s[dba_pkg::MR_BL_LSB +: 3] == dba_pkg::BL_CODE8) begin
        bl8_q <= 1'b1;
      end
      bt_q <= addr_s[dba_pkg::MR_BT_BIT];
      cl_q <= addr_s[dba_pkg::MR_CL_LSB +: 3];
      wr_q <= addr_s[dba_pkg::MR_WR_LSB +: 3];
    end else if (cmd_mrs && ba_s == dba_pkg::BA_EMR1) begin
      al_q <= addr_s[dba_pkg::EMR_AL_LSB +: 3];
    end
  end

  assign rl = 4'(al_q) + 4'(cl_q);
  assign wl = rl - 4'h1;

  // ==========================================================================
  // Latency line
  // Each slot is one link clock; a command enters at slot latency minus one and
  // starts its burst on the rise after it reaches slot zero, so bursts follow back to back.
  dba_pkg::dba_cmd_s lat_q [dba_pkg::LAT_DEPTH];
  dba_pkg::dba_cmd_s new_cmd;
  logic [3:0] ins_idx;

  assign ins_idx = (cmd_wr ? wl : rl) - 4'h1;
  assign new_cmd = '{valid: 1'b1, wr: cmd_wr, ap: addr_s[dba_pkg::AP_BIT],
                     bank: ba_s, col: addr_s[dba_pkg::COL_W-1:0]};

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < dba_pkg::LAT_DEPTH; i++) begin
        lat_q[i] <= '0;
      end
    end else if (ck_rise) begin
      for (int i = 0; i < dba_pkg::LAT_DEPTH - 1; i++) begin
        lat_q[i] <= lat_q[i+1];
      end
      lat_q[dba_pkg::LAT_DEPTH-1] <= '0;
      if (cmd_rd || cmd_wr) begin
        lat_q[ins_idx] <= new_cmd;
      end
    end
  end

  // ==========================================================================
  // Burst engine
  // A new start always overrides the running burst; that is how a permitted
  // interrupt two clocks after its predecessor cuts an eight-beat burst.
  dba_pkg::dba_state_e state_q;
  dba_pkg::dba_cmd_s cur_q;
  logic [2:0] beat_q;
  logic [3:0] wr_cnt_q;
  logic start, start_rd, beat_last, wr_cap;
  logic [dba_pkg::MEM_AW-1:0] rd_addr, wr_addr;
  logic [2:0] rd_idx;

  assign start = ck_rise & lat_q[0].valid;
  assign start_rd = start & ~lat_q[0].wr;
  assign beat_last = beat_q == (bl8_q ? 3'h7 : 3'h3);
  assign wr_cap = (state_q == dba_pkg::ST_WR) &&
                  (wr_cnt_q != (bl8_q ? 4'h8 : 4'h4)) &&
                  (dqs_rise || (dqs_fall && wr_cnt_q != 4'h0));

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= dba_pkg::ST_IDLE;
      cur_q <= '0;
      beat_q <= 3'h0;
      wr_cnt_q <= 4'h0;
    end else if (start) begin
      state_q <= lat_q[0].wr ? dba_pkg::ST_WR : dba_pkg::ST_RD;
      cur_q <= lat_q[0];
      beat_q <= 3'h0;
      wr_cnt_q <= 4'h0;
    end else begin
      case (state_q)
        dba_pkg::ST_RD: begin
          if (ck_rise || ck_fall) begin
            if (beat_last) begin
              state_q <= dba_pkg::ST_IDLE;
            end else begin
              beat_q <= beat_q + 3'h1;
            end
          end
        end
        dba_pkg::ST_WR: begin
          if (wr_cap) begin
            wr_cnt_q <= wr_cnt_q + 4'h1;
          end else if (wr_cnt_q == (bl8_q ? 4'h8 : 4'h4)) begin
            state_q <= dba_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= dba_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Storage
  // Only one open row per bank is modelled; row addresses are not kept.
  logic [dba_pkg::DQ_W-1:0] mem [2**dba_pkg::MEM_AW];

  assign rd_idx = start_rd ? 3'h0 : beat_q + 3'h1;
  assign rd_addr = {start_rd ? lat_q[0].bank : cur_q.bank,
                    dba_pkg::dba_beat_col(start_rd ? lat_q[0].col : cur_q.col,
                                          rd_idx, bl8_q, bt_q)};
  assign wr_addr = {cur_q.bank, dba_pkg::dba_beat_col(cur_q.col,
                    wr_cnt_q[2:0], bl8_q, bt_q)};

  always_ff @(posedge i_ref_clk) begin
    for (int l = 0; l < dba_pkg::DM_W; l++) begin
      if (wr_cap && !dm_s[l]) begin
        mem[wr_addr][l*8 +: 8] <= dq_s[l*8 +: 8];
      end
    end
  end

  // ==========================================================================
  // Read output and strobe
  logic post_q;
  logic pre_rd;

  assign pre_rd = ck_rise & lat_q[1].valid & ~lat_q[1].wr;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dq <= '0;
      o_dq_oe <= 1'b0;
      o_dqs <= 1'b0;
      o_dqs_oe <= 1'b0;
      post_q <= 1'b0;
    end else if (start_rd) begin
      o_dq <= mem[rd_addr];
      o_dq_oe <= 1'b1;
      o_dqs <= 1'b1;
      o_dqs_oe <= 1'b1;
      post_q <= 1'b0;
    end else if (state_q == dba_pkg::ST_RD && (ck_rise || ck_fall) &&
                 !beat_last) begin
      o_dq <= mem[rd_addr];
      o_dqs <= ck_rise;
    end else if ((state_q == dba_pkg::ST_RD && ck_rise) || pre_rd) begin
      o_dq_oe <= 1'b0;
      o_dqs <= 1'b0;
      o_dqs_oe <= 1'b1;
      post_q <= 1'b1;
    end else if (ck_fall && post_q && !(lat_q[0].valid && !lat_q[0].wr)) begin
      o_dqs_oe <= 1'b0;
      post_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Bank state and auto-precharge
  // Auto-precharge is timed from the programmed length, never the cut one.
  logic [3:0] bank_open_q;
  logic [4:0] ap_cnt_q;
  logic [dba_pkg::BA_W-1:0] ap_bank_q;
  logic ap_fire;

  assign ap_fire = ck_rise && ap_cnt_q == 5'h01;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ap_cnt_q <= 5'h00;
      ap_bank_q <= '0;
    end else if (start && lat_q[0].ap) begin
      ap_cnt_q <= (bl8_q ? dba_pkg::HALF_BL8 : dba_pkg::HALF_BL4) +
                  (lat_q[0].wr ? 5'(wr_q) + 5'h01 : 5'h00);
      ap_bank_q <= lat_q[0].bank;
    end else if (ck_rise && ap_cnt_q != 5'h00) begin
      ap_cnt_q <= ap_cnt_q - 5'h01;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bank_open_q <= 4'h0;
    end else if (cmd_pre && addr_s[dba_pkg::AP_BIT]) begin
      bank_open_q <= 4'h0;
    end else begin
      if (cmd_act) begin
        bank_open_q[ba_s] <= 1'b1;
      end
      if (cmd_pre) begin
        bank_open_q[ba_s] <= 1'b0;
      end
      if (ap_fire) begin
        bank_open_q[ap_bank_q] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Register port
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_q <= dba_pkg::CTRL_EN_RST;
    end else if (i_reg_wr && i_reg_addr == dba_pkg::OFS_CTRL) begin
      en_q <= i_reg_wdata[dba_pkg::CTRL_EN_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (!i_reg_rd) begin
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      case (i_reg_addr)
        dba_pkg::OFS_CTRL: o_reg_rdata <= {31'h0, en_q};
        dba_pkg::OFS_STATUS: o_reg_rdata <= {25'h0, state_q, bank_open_q};
        dba_pkg::OFS_MODE: o_reg_rdata <= {21'h0, wr_q, al_q, cl_q, bt_q,
                                           bl8_q};
        default: o_reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  logic mrs_bl_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mrs_bl_q <= 1'b0;
    end else begin
      mrs_bl_q <= cmd_mrs && ba_s == dba_pkg::BA_MR;
    end
  end

  a_mode_bl_bt: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (cmd_mrs && ba_s == dba_pkg::BA_MR && addr_s[2:0] == dba_pkg::BL_CODE8)
    |=> (bl8_q && bt_q == $past(addr_s[3])))
    else $error("Mode write did not set length eight and type.");

  a_bl_stable: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (!mrs_bl_q && !(cmd_mrs && ba_s == dba_pkg::BA_MR)) |=> $stable(bl8_q))
    else $error("Burst length changed without a mode write.");

  a_type_latch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    $changed(bt_q) |-> mrs_bl_q)
    else $error("Burst type changed without a mode write.");

  a_seq_order: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (wr_cap && !bt_q) |->
    wr_addr[1:0] == 2'(cur_q.col[1:0] + wr_cnt_q[1:0]))
    else $error("Sequential beat column is wrong.");

  a_il_order: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (wr_cap && bt_q && bl8_q) |->
    wr_addr[2:0] == (cur_q.col[2:0] ^ wr_cnt_q[2:0]))
    else $error("Interleaved beat column is wrong.");

  a_rd_launch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    start_rd |=> (o_dq_oe && o_dqs && o_dqs_oe))
    else $error("Read data did not launch at latency.");

  a_rd_preamble: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (pre_rd && state_q == dba_pkg::ST_IDLE) |=>
    (o_dqs_oe && !o_dqs && !o_dq_oe))
    else $error("Read strobe preamble missing.");

  a_wr_cap_stop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    wr_cap |-> wr_cnt_q < (bl8_q ? 4'h8 : 4'h4))
    else $error("Write beat captured past burst length.");

  a_pre_all: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (cmd_pre && addr_s[dba_pkg::AP_BIT]) |=> bank_open_q == 4'h0)
    else $error("Precharge all left a bank open.");

  a_ap_close: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (ap_fire && !cmd_act) |=> !bank_open_q[$past(ap_bank_q)])
    else $error("Auto-precharge did not close its bank.");

  a_rd_no_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (state_q == dba_pkg::ST_RD) |-> !wr_cap)
    else $error("Storage written during a read burst.");

endmodule : dba_burst_access

// File: verif/dba_ctl_model.sv
// Behavioural memory controller on the link side of the burst block.
`timescale 1ns/1ps
module dba_ctl_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  output logic o_ck,
  output logic o_cs_b,
  output logic [2:0] o_cmd,
  output logic [1:0] o_ba,
  output logic [12:0] o_addr,
  output logic [15:0] o_dq,
  output logic [1:0] o_dm,
  output logic o_dqs
);
  logic [2:0] ph_q;
  logic cs_b_drv;
  logic [2:0] cmd_drv;

  // A controller in reset keeps the device deselected with a no-op code.
  assign o_cs_b = cs_b_drv | ~i_rst_b;
  assign o_cmd = cmd_drv | {3{~i_rst_b}};

  // ==========================================================================
  // Link clock
  // The link clock runs free, eight reference cycles to a period.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ph_q <= 3'h4;
      o_ck <= 1'b0;
    end else begin
      ph_q <= ph_q + 3'h1;
      o_ck <= (ph_q == 3'h7) || (ph_q < 3'h3);
    end
  end

  initial begin
    cs_b_drv = 1'b1;
    cmd_drv = 3'h7;
    o_ba = 2'h0;
    o_addr = 13'h0;
    o_dq = 16'h0;
    o_dm = 2'h0;
    o_dqs = 1'b1;
  end

  // ==========================================================================
  // Link tasks
  task automatic wait_ph(input logic [2:0] p);
    do @(posedge i_ref_clk); while (ph_q !== p);
  endtask : wait_ph

  // Commands change on the falling link edge, centred on the taking rise.
  // Back-to-back calls therefore land exactly two link clocks apart.
  task automatic cmd(input logic [2:0] c, input logic [1:0] ba,
                     input logic [12:0] a);
    wait_ph(3'h3);
    cs_b_drv <= 1'b0;
    cmd_drv <= c;
    o_ba <= ba;
    o_addr <= a;
    wait_ph(3'h3);
    cs_b_drv <= 1'b1;
    cmd_drv <= ~c;
    o_ba <= ~ba;
    o_addr <= ~a;
  endtask : cmd

  // Data change on link edges and the strobe a quarter period later, so the
  // strobe sits mid-eye; released lines flip so stale values never pass.
  task automatic wr_burst(input logic [15:0] d[$], input logic [1:0] m[$],
                          input int wl);
    for (int j = 1; j < wl; j++) wait_ph(3'h3);
    o_dqs <= 1'b0;
    foreach (d[k]) begin
      wait_ph(k[0] ? 3'h3 : 3'h7);
      o_dq <= d[k];
      o_dm <= m[k];
      wait_ph(k[0] ? 3'h5 : 3'h1);
      o_dqs <= ~k[0];
    end
    wait_ph(3'h3);
    o_dqs <= 1'b1;
    o_dq <= ~o_dq;
    o_dm <= ~o_dm;
  endtask : wr_burst
endmodule : dba_ctl_model

// File: verif/tb_dba_burst_access.sv
// Self-checking testbench of the burst access block.
`timescale 1ns/1ps
module tb_dba_burst_access;
  logic clk, rst_b, ck, cs_b, m_dqs, dq_oe, dqs, dqs_oe, dqs_w;
  logic [2:0] cmd;
  logic [1:0] ba, m_dm;
  logic [12:0] addr;
  logic [15:0] m_dq, dut_dq, dq_w;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd;
  int num_errors = 0;
  int comparisons = 0;

  assign dq_w = dq_oe ? dut_dq : m_dq;
  assign dqs_w = dqs_oe ? dqs : m_dqs;

  dba_burst_access u_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_ck(ck),
    .i_cs_b(cs_b), .i_ras_b(cmd[2]), .i_cas_b(cmd[1]), .i_we_b(cmd[0]),
    .i_ba(ba), .i_addr(addr), .i_dq(dq_w), .i_dm(m_dm), .i_dqs(dqs_w),
    .o_dq(dut_dq), .o_dq_oe(dq_oe), .o_dqs(dqs), .o_dqs_oe(dqs_oe),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata));

  dba_ctl_model u_ctl (.i_ref_clk(clk), .i_rst_b(rst_b), .o_ck(ck),
    .o_cs_b(cs_b), .o_cmd(cmd), .o_ba(ba), .o_addr(addr), .o_dq(m_dq),
    .o_dm(m_dm), .o_dqs(m_dqs));

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic reg_wr_t(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_wr_t

  task automatic reg_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask : reg_chk

  // Samples sit mid-beat, so the synchroniser delay inside does not matter.
  task automatic rd_chk(input logic [15:0] e[$], input int rl);
    for (int j = 0; j < rl; j++) u_ctl.wait_ph(3'h4);
    chk({dqs_oe, dqs, dq_oe}, 3'b100);
    foreach (e[k]) begin
      u_ctl.wait_ph(k[0] ? 3'h0 : 3'h4);
      chk({dq_oe, dqs, dut_dq}, {1'b1, ~k[0], e[k]});
    end
    u_ctl.wait_ph(3'h4);
    chk({dq_oe, dqs}, 2'b00);
    u_ctl.wait_ph(3'h0);
    chk(dqs_oe, 1'b0);
  endtask : rd_chk

  function automatic logic [2:0] col_of(input logic [2:0] s,
    input logic [2:0] k, input logic bl8, input logic il);
    logic [2:0] c;
    c[1:0] = il ? (s[1:0] ^ k[1:0]) : (s[1:0] + k[1:0]);
    c[2] = bl8 ? (s[2] ^ k[2]) : s[2];
    return c;
  endfunction : col_of

  task automatic end_sim();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // ==========================================================================
  // Clock, watchdog and tests
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial begin
    logic [15:0] d[$];
    logic [15:0] e[$];
    logic [1:0] m[$];
    int bl8, il, cl, al, rl, s;
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    reg_chk(dba_pkg::OFS_CTRL, 32'h1);
    reg_chk(dba_pkg::OFS_STATUS, 32'h10);
    reg_chk(dba_pkg::OFS_MODE, 32'h20C);
    reg_wr_t(dba_pkg::OFS_MODE, 32'hFFF);
    reg_chk(dba_pkg::OFS_MODE, 32'h20C);
    reg_chk(4'hC, 32'h0);
    reg_wr_t(dba_pkg::OFS_CTRL, 32'h0);
    u_ctl.cmd(dba_pkg::CMD_ACT, 2'h0, 13'h0);
    u_ctl.wait_ph(3'h3);
    reg_chk(dba_pkg::OFS_STATUS, 32'h10);
    reg_wr_t(dba_pkg::OFS_CTRL, 32'h1);
    for (int b = 0; b < 4; b++) u_ctl.cmd(dba_pkg::CMD_ACT, 2'(b), 13'h0);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      bl8 = c / 2;
      il = c % 2;
      cl = 3 + il;
      al = 2 * bl8;
      rl = cl + al;
      s = bl8 ? 5 : 3;
      u_ctl.cmd(dba_pkg::CMD_MRS, dba_pkg::BA_EMR1, 13'(al * 8));
      u_ctl.cmd(dba_pkg::CMD_MRS, dba_pkg::BA_MR,
                13'(32'h400 + cl * 16 + il * 8 + 2 + bl8));
      u_ctl.cmd(dba_pkg::CMD_MRS, dba_pkg::BA_MR,
                13'(32'h400 + cl * 16 + il * 8 + 4 * bl8 + il));
      u_ctl.wait_ph(3'h3);
      reg_chk(dba_pkg::OFS_MODE,
              32'(32'h200 + al * 32 + cl * 4 + il * 2 + bl8));
      d = {};
      m = {};
      e = {};
      for (int k = 0; k < 4 + 4 * bl8; k++) begin
        d.push_back({4'(c + 1), 8'h5A, 4'(k)});
        m.push_back(2'h0);
        e.push_back({4'(c + 1), 8'h5A, 1'b0,
                     col_of(3'(s), 3'(k), bl8[0], il[0])});
      end
      u_ctl.cmd(dba_pkg::CMD_WR, 2'(c), 13'h0);
      u_ctl.wr_burst(d, m, rl - 1);
      u_ctl.cmd(dba_pkg::CMD_RD, 2'(c), 13'(s));
      rd_chk(e, rl);
      $display("test burst order %0d done", c);
    end
    e = {};
    for (int k = 0; k < 12; k++) begin
      e.push_back({k < 4 ? 4'h3 : 4'h4, 8'h5A, 4'(k < 4 ? k : k - 4)});
    end
    u_ctl.cmd(dba_pkg::CMD_RD, 2'h2, 13'h0);
    fork
      u_ctl.cmd(dba_pkg::CMD_RD, 2'h3, 13'h400);
      rd_chk(e, 6);
    join
    reg_chk(dba_pkg::OFS_STATUS, 32'h17);
    $display("test interrupt done");
    u_ctl.cmd(dba_pkg::CMD_MRS, dba_pkg::BA_EMR1, 13'h0);
    u_ctl.cmd(dba_pkg::CMD_MRS, dba_pkg::BA_MR, 13'h432);
    u_ctl.cmd(dba_pkg::CMD_WR, 2'h0, 13'h8);
    u_ctl.wr_burst({16'h1122, 16'h3344, 16'h5566, 16'h7788},
                   {2'h0, 2'h0, 2'h0, 2'h0}, 2);
    u_ctl.cmd(dba_pkg::CMD_WR, 2'h0, 13'h8);
    u_ctl.wr_burst({16'hAABB, 16'hCCDD, 16'hEEFF, 16'h0990, 16'hDEAD,
                    16'hBEEF}, {2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0}, 2);
    e = {16'hAA22, 16'h33DD, 16'h5566, 16'h0990,
         16'h25A0, 16'h25A1, 16'h25A2, 16'h25A3};
    u_ctl.cmd(dba_pkg::CMD_RD, 2'h0, 13'h8);
    fork
      u_ctl.cmd(dba_pkg::CMD_RD, 2'h1, 13'h0);
      rd_chk(e, 3);
    join
    $display("test mask done");
    u_ctl.cmd(3'h6, 2'h0, 13'h0);
    u_ctl.cmd(dba_pkg::CMD_PRE, 2'h2, 13'h0);
    u_ctl.wait_ph(3'h3);
    reg_chk(dba_pkg::OFS_STATUS, 32'h13);
    u_ctl.cmd(dba_pkg::CMD_PRE, 2'h1, 13'h400);
    u_ctl.wait_ph(3'h3);
    reg_chk(dba_pkg::OFS_STATUS, 32'h10);
    $display("test precharge done");
    end_sim();
  end
endmodule : tb_dba_burst_access
